// [verilog/csc_pkg.sv]
// constants and carrier types shared by the capacitive sense control block
package csc_pkg;
  // bus geometry
  localparam int CSC_DATA_W = 32;
  localparam int CSC_ADDR_W = 4;
  localparam int CSC_UNITS = 2;
  localparam int CSC_PADS = 16;
  localparam int CSC_CH_W = 4;

  // register byte offsets, one aligned word each
  localparam logic [3:0] CSC_OFF_A_CTRL = 4'h0;
  localparam logic [3:0] CSC_OFF_A_CHAN = 4'h4;
  localparam logic [3:0] CSC_OFF_B_CTRL = 4'h8;
  localparam logic [3:0] CSC_OFF_B_CHAN = 4'hc;

  // control register field positions
  localparam int CSC_BIT_ON = 7;
  localparam int CSC_BIT_RM = 6;
  localparam int CSC_BIT_RNG_HI = 3;
  localparam int CSC_BIT_RNG_LO = 2;
  localparam int CSC_BIT_DIR = 1;
  localparam int CSC_BIT_XCS = 0;

  // field values
  localparam logic [1:0] CSC_RNG_OFF = 2'h0;
  localparam logic [3:0] CSC_CHAN_RST = 4'h0;
  localparam logic [CSC_PADS-1:0] CSC_PAD_ONE = 16'h0001;
  localparam logic [CSC_PADS-1:0] CSC_PAD_NONE = 16'h0000;

  // axi responses
  localparam logic [1:0] CSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] CSC_RESP_SLVERR = 2'h2;

  // clock source seen by the paired timer
  typedef enum logic [2:0] {
    CSC_SRC_INSTR = 3'b001,
    CSC_SRC_PIN = 3'b010,
    CSC_SRC_OSC = 3'b100
  } csc_src_t;

  // software-written control bits of one unit
  typedef struct packed {
    logic on;
    logic rm;
    logic [1:0] rng;
    logic xcs;
  } csc_ctrl_t;

  localparam csc_ctrl_t CSC_CTRL_RST = '{on: 1'b0, rm: 1'b0, rng: 2'h0, xcs: 1'b0};

  // steering outputs of one unit
  typedef struct packed {
    logic unit_on;
    logic ref_external;
    logic osc_run;
    logic noise_mode;
    logic [1:0] current_sel;
    logic [CSC_PADS-1:0] pad_sel;
    csc_src_t timer_src;
    logic timer_tick;
    logic gated_tick;
  } csc_unit_out_t;

  localparam csc_unit_out_t CSC_OUT_RST = '{
    unit_on: 1'b0, ref_external: 1'b0, osc_run: 1'b0, noise_mode: 1'b0,
    current_sel: 2'h0, pad_sel: 16'h0000, timer_src: CSC_SRC_INSTR,
    timer_tick: 1'b0, gated_tick: 1'b0};
endpackage

// [verilog/csc_unit.sv]
// one sense unit: oscillator steering, pad select and timer clock routing
`timescale 1ns/1ps
`default_nettype none
module csc_unit
  import csc_pkg::*;
#(
  parameter int N_PADS = CSC_PADS
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  // register contents
  input wire csc_ctrl_t i_ctrl,
  input wire logic [CSC_CH_W-1:0] i_chan,
  // oscillator and timer side
  input wire logic i_osc_level,
  input wire logic i_clk_origin,
  input wire logic i_ext_pin,
  input wire logic i_instr_tick,
  input wire logic i_sleep,
  // status and steering
  output logic o_dir,
  output csc_unit_out_t o_out
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic sync3;
    logic ext_prev;
    logic dir;
    csc_unit_out_t out;
  } csc_unit_st_t;

  localparam csc_unit_st_t ST_RST = '{
    sync1: 1'b0, sync2: 1'b0, sync3: 1'b0, ext_prev: 1'b0, dir: 1'b0,
    out: CSC_OUT_RST};

  csc_unit_st_t s_r;
  csc_unit_st_t s_nxt;
  logic osc_rise;
  logic pin_rise;
  logic src_tick;

  initial begin
    if (N_PADS != CSC_PADS) $error("csc_unit: pad count must match the channel field");
  end

  // next state; sync1 feeds only sync2, edges look at later stages
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync1 = i_osc_level;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sync3 = s_r.sync2;
    s_nxt.ext_prev = i_ext_pin;
    osc_rise = s_r.sync2 & ~s_r.sync3;
    pin_rise = i_ext_pin & ~s_r.ext_prev;
    s_nxt.dir = s_r.sync2;
    s_nxt.out.unit_on = i_ctrl.on;
    s_nxt.out.ref_external = i_ctrl.on & i_ctrl.rm;
    // rm bit set keeps the loop alive at 00 for noise sensing
    s_nxt.out.osc_run = i_ctrl.on & (i_ctrl.rm | (i_ctrl.rng != CSC_RNG_OFF));
    s_nxt.out.noise_mode = i_ctrl.on & i_ctrl.rm & (i_ctrl.rng == CSC_RNG_OFF);
    s_nxt.out.current_sel = i_ctrl.on ? i_ctrl.rng : CSC_RNG_OFF;
    // disabled unit ignores the channel field
    s_nxt.out.pad_sel = i_ctrl.on ? (CSC_PAD_ONE << i_chan) : CSC_PAD_NONE;
    if (!i_clk_origin) begin
      s_nxt.out.timer_src = CSC_SRC_INSTR;
      src_tick = i_instr_tick;
    end else if (i_ctrl.xcs) begin
      s_nxt.out.timer_src = CSC_SRC_OSC;
      src_tick = osc_rise & i_ctrl.on;
    end else begin
      s_nxt.out.timer_src = CSC_SRC_PIN;
      src_tick = pin_rise;
    end
    // paired timer halts in sleep; gated timers may keep counting
    s_nxt.out.timer_tick = src_tick & ~i_sleep;
    s_nxt.out.gated_tick = osc_rise & i_ctrl.on;
  end

  // frozen while the clock enable is low
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= ST_RST;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  assign o_dir = s_r.dir;
  assign o_out = s_r.out;
endmodule
`default_nettype wire

// [verilog/csc_top.sv]
// capacitive sense control: axi4-lite registers and two sense units
// Operation
// - control bit 7 one turns the sensing unit on, zero keeps it off.
// - bit 6 set picks external references, clear picks internal references.
// - internal references: current field 00 stops oscillator, else low/medium/high.
// - external references: 00 is noise detection, no current; else low/medium/high.
// - read-only bit 1 is one while sourcing current, zero while sinking.
// - timer origin bit set: bit 0 picks oscillator (1) or external pin (0).
// - timer origin bit clear: timer runs from instruction clock regardless of bit 0.
// - disabled unit ignores channel field and connects no pad.
// - enabled unit connects the pad whose index equals the channel field.
// - control bits 5-4 and channel bits 7-4 read zero.
// - all implemented control and channel bits clear to zero on reset.
// - oscillator keeps running while enabled, asleep or not.
// - paired timers do not count during sleep.
// - counting may go on in sleep; evaluation needs the device awake.
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module csc_top
  import csc_pkg::*;
#(
  parameter int ADDR_W = CSC_ADDR_W,
  parameter int N_PADS = CSC_PADS
) (
  // clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  // axi4-lite write address
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  // axi4-lite write data
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [CSC_DATA_W-1:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // axi4-lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read address
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  // axi4-lite read data
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [CSC_DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp,
  // per-unit analog and timer side, index 0 is unit a
  input wire logic [CSC_UNITS-1:0] i_osc_level,
  input wire logic [CSC_UNITS-1:0] i_clk_origin,
  input wire logic [CSC_UNITS-1:0] i_ext_pin,
  input wire logic i_instr_tick,
  input wire logic i_sleep,
  // per-unit steering outputs
  output csc_unit_out_t [CSC_UNITS-1:0] o_unit
);
  // bus-side state, one packed record
  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [CSC_DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [CSC_DATA_W-1:0] rdata;
    csc_ctrl_t [CSC_UNITS-1:0] ctrl;
    logic [CSC_UNITS-1:0][CSC_CH_W-1:0] chan;
  } csc_top_st_t;

  csc_top_st_t s_r;
  csc_top_st_t s_nxt;
  logic [CSC_UNITS-1:0] unit_dir;
  logic aw_take;
  logic w_take;
  logic ar_take;

  initial begin
    if (ADDR_W < CSC_ADDR_W) $error("csc_top: address too narrow for the map");
    if (N_PADS != CSC_PADS) $error("csc_top: pad count must be sixteen");
  end

  // full-address match; upper bits must be zero to hit a register
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
    hit = (a == ADDR_W'(off));
  endfunction

  // unit index and register kind of a mapped address
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, CSC_OFF_A_CTRL) | hit(a, CSC_OFF_A_CHAN) |
             hit(a, CSC_OFF_B_CTRL) | hit(a, CSC_OFF_B_CHAN);
  endfunction

  function automatic logic unit_of(input logic [ADDR_W-1:0] a);
    unit_of = hit(a, CSC_OFF_B_CTRL) | hit(a, CSC_OFF_B_CHAN);
  endfunction

  function automatic logic is_chan(input logic [ADDR_W-1:0] a);
    is_chan = hit(a, CSC_OFF_A_CHAN) | hit(a, CSC_OFF_B_CHAN);
  endfunction

  // read word of a control register; gap bits stay zero
  function automatic logic [CSC_DATA_W-1:0] ctrl_word(input csc_ctrl_t c, input logic d);
    logic [CSC_DATA_W-1:0] w;
    w = '0;
    w[CSC_BIT_ON] = c.on;
    w[CSC_BIT_RM] = c.rm;
    w[CSC_BIT_RNG_HI:CSC_BIT_RNG_LO] = c.rng;
    w[CSC_BIT_DIR] = d;
    w[CSC_BIT_XCS] = c.xcs;
    ctrl_word = w;
  endfunction

  // read word of a channel register; upper bits stay zero
  function automatic logic [CSC_DATA_W-1:0] chan_word(input logic [CSC_CH_W-1:0] c);
    chan_word = {{(CSC_DATA_W - CSC_CH_W){1'b0}}, c};
  endfunction

  // handshake readies; withheld while frozen so no beat is lost
  always_comb begin
    o_awready = i_ce & ~s_r.aw_held & ~s_r.bvalid;
    o_wready = i_ce & ~s_r.w_held & ~s_r.bvalid;
    o_arready = i_ce & ~s_r.rvalid;
    aw_take = i_awvalid & o_awready;
    w_take = i_wvalid & o_wready;
    ar_take = i_arvalid & o_arready;
  end

  // bus and register next state
  always_comb begin
    logic u;
    u = 1'b0;
    s_nxt = s_r;
    // address and data are caught independently, in either order
    if (aw_take) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = i_awaddr;
    end
    if (w_take) begin
      s_nxt.w_held = 1'b1;
      s_nxt.w_data = i_wdata;
      s_nxt.w_strb = i_wstrb;
    end
    // commit once both halves are held, then answer
    if (s_r.aw_held && s_r.w_held) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = mapped(s_r.aw_addr) ? CSC_RESP_OKAY : CSC_RESP_SLVERR;
      u = unit_of(s_r.aw_addr);
      // only byte lane 0 carries implemented bits
      if (mapped(s_r.aw_addr) && s_r.w_strb[0]) begin
        if (is_chan(s_r.aw_addr)) begin
          s_nxt.chan[u] = s_r.w_data[CSC_CH_W-1:0];
        end else begin
          // status bit 1 is not writable
          s_nxt.ctrl[u].on = s_r.w_data[CSC_BIT_ON];
          s_nxt.ctrl[u].rm = s_r.w_data[CSC_BIT_RM];
          s_nxt.ctrl[u].rng = s_r.w_data[CSC_BIT_RNG_HI:CSC_BIT_RNG_LO];
          s_nxt.ctrl[u].xcs = s_r.w_data[CSC_BIT_XCS];
        end
      end
    end else if (s_r.bvalid && i_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // reads answer at the same edge that takes the address
    if (ar_take) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = mapped(i_araddr) ? CSC_RESP_OKAY : CSC_RESP_SLVERR;
      if (!mapped(i_araddr)) begin
        s_nxt.rdata = '0;
      end else if (is_chan(i_araddr)) begin
        s_nxt.rdata = chan_word(s_r.chan[unit_of(i_araddr)]);
      end else begin
        s_nxt.rdata = ctrl_word(s_r.ctrl[unit_of(i_araddr)], unit_dir[unit_of(i_araddr)]);
      end
    end else if (s_r.rvalid && i_rready) begin
      s_nxt.rvalid = 1'b0;
    end
  end

  // register update; reset clears every implemented bit
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s_r.aw_held <= 1'b0;
      s_r.aw_addr <= '0;
      s_r.w_held <= 1'b0;
      s_r.w_data <= '0;
      s_r.w_strb <= '0;
      s_r.bvalid <= 1'b0;
      s_r.bresp <= CSC_RESP_OKAY;
      s_r.rvalid <= 1'b0;
      s_r.rresp <= CSC_RESP_OKAY;
      s_r.rdata <= '0;
      s_r.ctrl <= {CSC_UNITS{CSC_CTRL_RST}};
      s_r.chan <= {CSC_UNITS{CSC_CHAN_RST}};
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  // bus outputs straight from flip-flops
  assign o_bvalid = s_r.bvalid;
  assign o_bresp = s_r.bresp;
  assign o_rvalid = s_r.rvalid;
  assign o_rresp = s_r.rresp;
  assign o_rdata = s_r.rdata;

  // one sense unit per register pair
  for (genvar g = 0; g < CSC_UNITS; g++) begin : g_unit
    csc_unit #(
      .N_PADS(N_PADS)
    ) u_unit (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_ctrl(s_r.ctrl[g]),
      .i_chan(s_r.chan[g]),
      .i_osc_level(i_osc_level[g]),
      .i_clk_origin(i_clk_origin[g]),
      .i_ext_pin(i_ext_pin[g]),
      .i_instr_tick(i_instr_tick),
      .i_sleep(i_sleep),
      .o_dir(unit_dir[g]),
      .o_out(o_unit[g])
    );
  end
endmodule
`default_nettype wire

// [dv/csc_tmr_model.sv]
// far-side counting timer that measures sense oscillations over a window
`timescale 1ns/1ps
`default_nettype none
module csc_tmr_model (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // count pulse and window strobes from a separate time base
  input wire logic i_tick,
  input wire logic i_clear,
  input wire logic i_store,
  // count captured at window end
  output logic [15:0] o_count
);
  logic [15:0] cnt_r;
  // store takes this edge's pulse too, so a window is whole edges
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= '0;
      o_count <= '0;
    end else if (i_clear) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 16'(i_tick);
      if (i_store) o_count <= cnt_r + 16'(i_tick);
    end
  end
endmodule
`default_nettype wire

// [dv/csc_top_monitor.sv]
// bus handshake and unit steering checks on the top ports
`timescale 1ns/1ps
`default_nettype none
module csc_top_monitor
  import csc_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // register bus
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [1:0] o_bresp,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [CSC_DATA_W-1:0] o_rdata,
  // unit side
  input wire logic i_sleep,
  input wire logic [CSC_UNITS-1:0] i_osc_level,
  input wire logic [CSC_UNITS-1:0] i_clk_origin,
  input wire csc_unit_out_t [CSC_UNITS-1:0] o_unit
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // both write halves taken at one edge
  sequence s_wr_take;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_two_late;
    !o_bvalid ##1 o_bvalid;
  endsequence
  property p_wr_lat;
    s_wr_take |=> s_two_late;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write response not two edges late");
  property p_rd_lat;
    i_arvalid && o_arready |=> o_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data late");
  property p_b_hold;
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_off;
    !o_unit[1].unit_on |-> o_unit[1].pad_sel == CSC_PAD_NONE;
  endproperty
  a_off: assert property (p_off) else $error("pad connected while off");
  property p_pad;
    o_unit[1].unit_on |-> $onehot(o_unit[1].pad_sel);
  endproperty
  a_pad: assert property (p_pad) else $error("not one pad while on");
  property p_noise;
    o_unit[0].noise_mode |-> o_unit[0].osc_run && o_unit[0].ref_external &&
      o_unit[0].current_sel == CSC_RNG_OFF;
  endproperty
  a_noise: assert property (p_noise) else $error("noise mode inconsistent");
  property p_sleep;
    i_sleep && $past(i_sleep) |-> !o_unit[0].timer_tick;
  endproperty
  a_sleep: assert property (p_sleep) else $error("paired timer ticked asleep");
  property p_gated;
    o_unit[0].unit_on && $rose(i_osc_level[0]) |-> ##[2:6] o_unit[0].gated_tick;
  endproperty
  a_gated: assert property (p_gated) else $error("oscillator edge lost");
  property p_src;
    !i_clk_origin[0] ##1 !i_clk_origin[0] |-> o_unit[0].timer_src == CSC_SRC_INSTR;
  endproperty
  a_src: assert property (p_src) else $error("timer not on instruction clock");
endmodule
bind csc_top csc_top_monitor csc_top_monitor_i (.*);
`default_nettype wire

// [dv/csc_top_tb.sv]
// self-checking bench for the capacitive sense control block
`timescale 1ns/1ps
`default_nettype none
module csc_top_tb;
  import csc_pkg::*;
  localparam int WIN = 96;
  logic i_mclk = 0, i_rst = 1, i_ce = 1, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  logic i_arvalid = 0, i_rready = 0, i_instr_tick = 0, i_sleep = 0;
  logic [4:0] i_awaddr = 0, i_araddr = 0;
  logic [2:0] i_awprot = 0, i_arprot = 0;
  logic [31:0] i_wdata = 0;
  logic [3:0] i_wstrb = 4'hf;
  logic [1:0] i_clk_origin = 0, i_ext_pin = 0, tk = 0;
  wire [1:0] i_osc_level;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  csc_unit_out_t [1:0] o_unit;
  logic osc = 0, hi = 0, clr = 0, sto = 0, pin = 0;
  logic [15:0] cnt_p, cnt_g;
  int per = 0, ph = 0, num_errors = 0, checked = 0;
  logic [4:0] ad [4] = '{5'h0, 5'h4, 5'h8, 5'hc};
  csc_top #(.ADDR_W(5)) csc_top_i (.*);
  // paired timer counts timer ticks, gated timer counts oscillator edges
  csc_tmr_model tmr_p (.i_mclk, .i_rst, .i_tick(o_unit[0].timer_tick), .i_clear(clr),
    .i_store(sto), .o_count(cnt_p));
  // gated timer counts the oscillator edges directly while the unit is on
  csc_tmr_model tmr_g (.i_mclk, .i_rst, .i_tick(o_unit[0].gated_tick), .i_clear(clr),
    .i_store(sto), .o_count(cnt_g));
  always #2 i_mclk = ~i_mclk;
  // instruction clock pulse every fourth cycle; oscillator of period per
  always @(posedge i_mclk) begin
    tk <= tk + 2'h1;
    i_instr_tick <= (tk == 2'h3);
    ph <= (ph >= per - 1) ? 0 : ph + 1;
    osc <= (per != 0) && (ph < per / 2);
    // external timer pin rises once every fourth cycle while enabled
    i_ext_pin <= {1'b0, pin & tk[1]};
  end
  assign i_osc_level = {1'b0, osc | hi};
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic axw(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er,
      input int dly);
    int n;
    n = 0;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_awaddr <= a;
    i_wdata <= d;
    i_bready <= (dly == 0);
    do begin
      @(posedge i_mclk);
      n++;
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      if (!(o_bvalid && i_bready)) i_bready <= (n >= dly);
    end while (!(o_bvalid && i_bready));
    i_bready <= 1'b0;
    chk(32'(o_bresp), 32'(er));
    @(posedge i_mclk);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er,
      input int dly);
    int n;
    n = 0;
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= (dly == 0);
    do begin
      @(posedge i_mclk);
      n++;
      if (o_arready) i_arvalid <= 1'b0;
      if (!(o_rvalid && i_rready)) i_rready <= (n >= dly);
    end while (!(o_rvalid && i_rready));
    i_rready <= 1'b0;
    chk(o_rdata, e);
    chk(32'(o_rresp), 32'(er));
    @(posedge i_mclk);
  endtask
  task automatic t_rst;
    i_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    foreach (ad[k]) rdc(ad[k], 32'h0, CSC_RESP_OKAY, 0);
    $display("reset test done");
  endtask
  task automatic t_regs;
    rdc(5'h10, 32'h0, CSC_RESP_SLVERR, 0);
    axw(ad[0], 32'hffff_ffff, CSC_RESP_OKAY, 3);
    rdc(ad[0], 32'hcd, CSC_RESP_OKAY, 3);
    axw(ad[1], 32'hff, CSC_RESP_OKAY, 0);
    i_wstrb <= 4'he;
    axw(ad[1], 32'h5, CSC_RESP_OKAY, 0);
    i_wstrb <= 4'hf;
    rdc(ad[1], 32'hf, CSC_RESP_OKAY, 0);
    axw(5'h10, 32'h0, CSC_RESP_SLVERR, 0);
    rdc(ad[0], 32'hcd, CSC_RESP_OKAY, 0);
    $display("register test done");
  endtask
  task automatic t_modes;
    for (int i = 0; i < 16; i++) begin
      axw(ad[0], {24'h0, i[3], i[2], 2'b00, i[1:0], 2'b00}, CSC_RESP_OKAY, 0);
      chk(32'({o_unit[0].unit_on, o_unit[0].ref_external, o_unit[0].osc_run,
        o_unit[0].noise_mode, o_unit[0].current_sel}), 32'({i[3], i[3] & i[2],
        i[3] & (i[2] | (i[1:0] != 2'h0)), i[3] & i[2] & (i[1:0] == 2'h0),
        i[3] ? i[1:0] : 2'h0}));
    end
    $display("mode test done");
  endtask
  task automatic t_pads;
    axw(ad[2], 32'h80, CSC_RESP_OKAY, 0);
    for (int c = 0; c < 16; c++) begin
      axw(ad[3], 32'hf0 | 32'(c), CSC_RESP_OKAY, 0);
      chk(32'(o_unit[1].pad_sel), 32'h1 << c);
      rdc(ad[3], 32'(c), CSC_RESP_OKAY, 0);
    end
    axw(ad[2], 32'h0, CSC_RESP_OKAY, 0);
    chk(32'(o_unit[1].pad_sel), 32'h0);
    $display("pad test done");
  endtask
  task automatic t_src;
    for (int j = 0; j < 4; j++) begin
      i_clk_origin <= {1'b0, j[1]};
      axw(ad[0], 32'h80 | 32'(j[0]), CSC_RESP_OKAY, 0);
      chk(32'(o_unit[0].timer_src), !j[1] ? 32'(CSC_SRC_INSTR) :
        j[0] ? 32'(CSC_SRC_OSC) : 32'(CSC_SRC_PIN));
    end
    $display("clock source test done");
  endtask
  // one fixed window of WIN edges, timed by the bench and not by the counters
  task automatic win(input int p);
    per <= p;
    repeat (2 * p) @(posedge i_mclk);
    clr <= 1'b1;
    @(posedge i_mclk);
    clr <= 1'b0;
    repeat (WIN - 1) @(posedge i_mclk);
    sto <= 1'b1;
    @(posedge i_mclk);
    sto <= 1'b0;
    @(posedge i_mclk);
  endtask
  // frozen bus: readies stay low while the clock enable is low
  task automatic t_ce;
    i_ce <= 1'b0;
    @(posedge i_mclk);
    chk(32'(o_awready), 32'h0);
    chk(32'(o_arready), 32'h0);
    i_ce <= 1'b1;
    @(posedge i_mclk);
    $display("clock enable test done");
  endtask
  task automatic t_meas;
    int base;
    base = 0;
    i_clk_origin <= 2'b01;
    axw(ad[1], 32'h3, CSC_RESP_OKAY, 0);
    axw(ad[0], 32'h8d, CSC_RESP_OKAY, 0);
    win(16);
    chk(32'(cnt_p), WIN / 16);
    base = int'(cnt_p);
    win(24);
    chk(32'(cnt_p), WIN / 24);
    // threshold midway: loaded count below it, baseline above it
    chk(32'(int'(cnt_p) < (base + int'(cnt_p)) / 2), 32'h1);
    chk(32'(base > (base + int'(cnt_p)) / 2), 32'h1);
    i_sleep <= 1'b1;
    win(16);
    chk(32'(cnt_p), 32'h0);
    chk(32'(cnt_g), WIN / 16);
    i_sleep <= 1'b0;
    per <= 0;
    hi <= 1'b1;
    repeat (8) @(posedge i_mclk);
    rdc(ad[0], 32'h8f, CSC_RESP_OKAY, 0);
    pin <= 1'b1;
    axw(ad[0], 32'h8c, CSC_RESP_OKAY, 0);
    win(0);
    chk(32'(cnt_p), WIN / 4);
    i_clk_origin <= 2'b00;
    pin <= 1'b0;
    win(0);
    chk(32'(cnt_p), WIN / 4);
    $display("measurement test done");
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog well beyond the thousand or so cycles the tests take
  initial begin
    #200000;
    num_errors++;
    final_report();
  end
  initial begin
    t_rst();
    t_regs();
    t_rst();
    t_modes();
    t_pads();
    t_src();
    t_ce();
    t_meas();
    final_report();
  end
endmodule
`default_nettype wire
